// File: rtl/rps_cfg.svh
// constants of the remappable pin select block
`ifndef RPS_CFG_SVH
`define RPS_CFG_SVH

// ************************************************************
// register bus
// ************************************************************
`define RPS_ADDR_W        4
`define RPS_DATA_W        16
`define RPS_IDX_FAULT     4'h0
`define RPS_IDX_OUT_61_60 4'h1
`define RPS_IDX_OUT_63_62 4'h2
`define RPS_RESET_VAL     16'h0000
`define RPS_OUT_MASK      16'h3F3F

// ************************************************************
// field positions
// ************************************************************
`define RPS_PWM_FAULT_INPUT_4_MSB      15
`define RPS_PWM_FAULT_INPUT_4_LSB      8
`define RPS_PWM_FAULT_INPUT_3_MSB      7
`define RPS_PWM_FAULT_INPUT_3_LSB      0
`define RPS_HI_MSB        13
`define RPS_HI_LSB        8
`define RPS_LO_MSB        5
`define RPS_LO_LSB        0

// ************************************************************
// code ranges
// ************************************************************
`define RPS_PIN_CNT       182
`define RPS_PIN_MAX       8'hB5
`define RPS_PIN_VSS       8'h00
`define RPS_FUNC_CNT      64
`define RPS_FUNC_NONE     6'h00
`define RPS_FUNC_VALID    64'hFFFF_FFFF_FFFF_FFFE

`endif

// File: rtl/rps_pkg.sv
// types of the remappable pin select block
package rps_pkg;
    typedef logic [7:0] rps_pin_sel_t;
    typedef logic [5:0] rps_func_sel_t;
    typedef logic [15:0] rps_word_t;
endpackage : rps_pkg

// File: rtl/rps_top.sv
// remappable pin select: fault input routing and output function routing
`timescale 1ns/100ps
`include "rps_cfg.svh"

module rps_top import rps_pkg::*; (
    input  wire logic                      clock,             // system clock, 125 MHz
    input  wire logic                      rst,               // synchronous reset, high
    input  wire logic [`RPS_ADDR_W-1:0]    addr,              // register index
    input  wire logic [`RPS_DATA_W-1:0]    wr_data,           // write data
    input  wire logic                      wr_en,             // write strobe
    input  wire logic                      rd_en,             // read strobe
    output logic      [`RPS_DATA_W-1:0]    rd_data,           // read data, cycle after rd_en
    input  wire logic [`RPS_PIN_CNT-1:0]   remappable_pin,    // raw pin levels, async
    input  wire logic [`RPS_FUNC_CNT-1:0]  periph_func,       // peripheral output functions
    output logic                           pwm_fault_input_4, // routed fault 4
    output logic                           pwm_fault_input_3, // routed fault 3
    output logic      [3:0]                rp_out,            // pins 63..60 output level
    output logic      [3:0]                rp_out_en          // pins 63..60 driven by a function
);

    // ************************************************************
    // selection functions
    // ************************************************************
    // code 0 is tied to ground; codes past the last pin stay unconnected (low)
    function automatic logic pick_pin(input logic [`RPS_PIN_CNT-1:0] pins,
                                      input rps_pin_sel_t sel);
        logic r;
        r = 1'b0;
        if (sel != `RPS_PIN_VSS && sel <= `RPS_PIN_MAX) begin
            r = pins[sel];
        end
        return r;
    endfunction : pick_pin

    // unassigned function numbers leave the pin undriven
    function automatic logic func_valid(input rps_func_sel_t sel);
        logic [`RPS_FUNC_CNT-1:0] v;
        v = `RPS_FUNC_VALID;
        return (sel != `RPS_FUNC_NONE) && v[sel];
    endfunction : func_valid

    function automatic logic pick_func(input logic [`RPS_FUNC_CNT-1:0] f,
                                       input rps_func_sel_t sel);
        return func_valid(sel) && f[sel];
    endfunction : pick_func

    // register index decode, shared by the three write paths
    function automatic logic reg_hit(input logic [`RPS_ADDR_W-1:0] a,
                                     input logic [`RPS_ADDR_W-1:0] idx);
        return a == idx;
    endfunction : reg_hit

    // unimplemented bits of the output-select words are never stored
    function automatic rps_word_t keep_out_bits(input rps_word_t w);
        return w & `RPS_OUT_MASK;
    endfunction : keep_out_bits

    // ************************************************************
    // fault input select register
    // ************************************************************
    rps_word_t fault_input_pin_select_reg;
    rps_word_t fault_input_pin_select_next;

    // every bit is a selector bit, so the word is kept whole
    always_comb begin
        fault_input_pin_select_next = fault_input_pin_select_reg;
        if (wr_en && reg_hit(addr, `RPS_IDX_FAULT)) begin
            fault_input_pin_select_next = wr_data;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            fault_input_pin_select_reg <= `RPS_RESET_VAL;
        end else begin
            fault_input_pin_select_reg <= fault_input_pin_select_next;
        end
    end

    // ************************************************************
    // output select register, pins 61 and 60
    // ************************************************************
    rps_word_t output_pin_select_61_60_reg;
    rps_word_t output_pin_select_61_60_next;

    // dropping bits 15:14 and 7:6 on the way in keeps them zero for reads
    always_comb begin
        output_pin_select_61_60_next = output_pin_select_61_60_reg;
        if (wr_en && reg_hit(addr, `RPS_IDX_OUT_61_60)) begin
            output_pin_select_61_60_next = keep_out_bits(wr_data);
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            output_pin_select_61_60_reg <= `RPS_RESET_VAL;
        end else begin
            output_pin_select_61_60_reg <= output_pin_select_61_60_next;
        end
    end

    // ************************************************************
    // output select register, pins 63 and 62
    // ************************************************************
    rps_word_t output_pin_select_63_62_reg;
    rps_word_t output_pin_select_63_62_next;

    always_comb begin
        output_pin_select_63_62_next = output_pin_select_63_62_reg;
        if (wr_en && reg_hit(addr, `RPS_IDX_OUT_63_62)) begin
            output_pin_select_63_62_next = keep_out_bits(wr_data);
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            output_pin_select_63_62_reg <= `RPS_RESET_VAL;
        end else begin
            output_pin_select_63_62_reg <= output_pin_select_63_62_next;
        end
    end

    // ************************************************************
    // read port
    // ************************************************************
    rps_word_t rd_data_reg;
    rps_word_t rd_data_next;

    // data stand one cycle only; idle cycles and unmapped indices read zero
    always_comb begin
        rd_data_next = `RPS_RESET_VAL;
        if (rd_en) begin
            case (addr)
                `RPS_IDX_FAULT:     rd_data_next = fault_input_pin_select_reg;
                `RPS_IDX_OUT_61_60: rd_data_next = output_pin_select_61_60_reg;
                `RPS_IDX_OUT_63_62: rd_data_next = output_pin_select_63_62_reg;
                default:            rd_data_next = `RPS_RESET_VAL;
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            rd_data_reg <= `RPS_RESET_VAL;
        end else begin
            rd_data_reg <= rd_data_next;
        end
    end

    assign rd_data = rd_data_reg;

    // ************************************************************
    // selector fields
    // ************************************************************
    rps_pin_sel_t  fault4_pin_selector;
    rps_pin_sel_t  fault3_pin_selector;
    rps_func_sel_t out_sel_pin_60;
    rps_func_sel_t out_sel_pin_61;
    rps_func_sel_t out_sel_pin_62;
    rps_func_sel_t out_sel_pin_63;

    assign fault4_pin_selector = fault_input_pin_select_reg[`RPS_PWM_FAULT_INPUT_4_MSB:`RPS_PWM_FAULT_INPUT_4_LSB];
    assign fault3_pin_selector = fault_input_pin_select_reg[`RPS_PWM_FAULT_INPUT_3_MSB:`RPS_PWM_FAULT_INPUT_3_LSB];
    assign out_sel_pin_61      = output_pin_select_61_60_reg[`RPS_HI_MSB:`RPS_HI_LSB];
    assign out_sel_pin_60      = output_pin_select_61_60_reg[`RPS_LO_MSB:`RPS_LO_LSB];
    assign out_sel_pin_63      = output_pin_select_63_62_reg[`RPS_HI_MSB:`RPS_HI_LSB];
    assign out_sel_pin_62      = output_pin_select_63_62_reg[`RPS_LO_MSB:`RPS_LO_LSB];

    // ************************************************************
    // pin input synchroniser
    // ************************************************************
    // pins are asynchronous; the first stage feeds only the second
    logic [`RPS_PIN_CNT-1:0] pin_meta_reg;
    logic [`RPS_PIN_CNT-1:0] pin_meta_next;
    logic [`RPS_PIN_CNT-1:0] pin_sync_reg;
    logic [`RPS_PIN_CNT-1:0] pin_sync_next;

    always_comb begin
        pin_meta_next = remappable_pin;
        pin_sync_next = pin_meta_reg;
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            pin_meta_reg <= '0;
            pin_sync_reg <= '0;
        end else begin
            pin_meta_reg <= pin_meta_next;
            pin_sync_reg <= pin_sync_next;
        end
    end

    // ************************************************************
    // fault input routing
    // ************************************************************
    logic fault4_reg;
    logic fault4_next;
    logic fault3_reg;
    logic fault3_next;

    // only the second synchroniser stage is read; pin edges show three edges later
    always_comb begin
        fault4_next = pick_pin(pin_sync_reg, fault4_pin_selector);
        fault3_next = pick_pin(pin_sync_reg, fault3_pin_selector);
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            fault4_reg <= 1'b0;
            fault3_reg <= 1'b0;
        end else begin
            fault4_reg <= fault4_next;
            fault3_reg <= fault3_next;
        end
    end

    assign pwm_fault_input_4 = fault4_reg;
    assign pwm_fault_input_3 = fault3_reg;

    // ************************************************************
    // pin 60 output
    // ************************************************************
    logic pin60_out_reg;
    logic pin60_out_next;
    logic pin60_en_reg;
    logic pin60_en_next;

    // one register stage so every output leaves a flip-flop
    always_comb begin
        pin60_out_next = pick_func(periph_func, out_sel_pin_60);
        pin60_en_next  = func_valid(out_sel_pin_60);
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            pin60_out_reg <= 1'b0;
            pin60_en_reg  <= 1'b0;
        end else begin
            pin60_out_reg <= pin60_out_next;
            pin60_en_reg  <= pin60_en_next;
        end
    end

    // ************************************************************
    // pin 61 output
    // ************************************************************
    logic pin61_out_reg;
    logic pin61_out_next;
    logic pin61_en_reg;
    logic pin61_en_next;

    always_comb begin
        pin61_out_next = pick_func(periph_func, out_sel_pin_61);
        pin61_en_next  = func_valid(out_sel_pin_61);
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            pin61_out_reg <= 1'b0;
            pin61_en_reg  <= 1'b0;
        end else begin
            pin61_out_reg <= pin61_out_next;
            pin61_en_reg  <= pin61_en_next;
        end
    end

    // ************************************************************
    // pin 62 output
    // ************************************************************
    logic pin62_out_reg;
    logic pin62_out_next;
    logic pin62_en_reg;
    logic pin62_en_next;

    always_comb begin
        pin62_out_next = pick_func(periph_func, out_sel_pin_62);
        pin62_en_next  = func_valid(out_sel_pin_62);
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            pin62_out_reg <= 1'b0;
            pin62_en_reg  <= 1'b0;
        end else begin
            pin62_out_reg <= pin62_out_next;
            pin62_en_reg  <= pin62_en_next;
        end
    end

    // ************************************************************
    // pin 63 output
    // ************************************************************
    logic pin63_out_reg;
    logic pin63_out_next;
    logic pin63_en_reg;
    logic pin63_en_next;

    always_comb begin
        pin63_out_next = pick_func(periph_func, out_sel_pin_63);
        pin63_en_next  = func_valid(out_sel_pin_63);
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            pin63_out_reg <= 1'b0;
            pin63_en_reg  <= 1'b0;
        end else begin
            pin63_out_reg <= pin63_out_next;
            pin63_en_reg  <= pin63_en_next;
        end
    end

    // ************************************************************
    // output pins
    // ************************************************************
    // bus order is pin 60 at bit 0 up to pin 63 at bit 3
    assign rp_out    = {pin63_out_reg, pin62_out_reg, pin61_out_reg, pin60_out_reg};
    assign rp_out_en = {pin63_en_reg, pin62_en_reg, pin61_en_reg, pin60_en_reg};

endmodule : rps_top

// File: tb/rps_checker.sv
// concurrent checks on the ports of the remappable pin select block
`timescale 1ns/100ps
module rps_checker (
    input wire logic         clock,             // clock
    input wire logic         rst,               // reset
    input wire logic [3:0]   addr,              // index
    input wire logic [15:0]  wr_data,           // wdata
    input wire logic         wr_en,             // write
    input wire logic         rd_en,             // read
    input wire logic [15:0]  rd_data,           // rdata
    input wire logic [181:0] remappable_pin,    // pins
    input wire logic [63:0]  periph_func,       // functions
    input wire logic         pwm_fault_input_4, // fault 4
    input wire logic         pwm_fault_input_3, // fault 3
    input wire logic [3:0]   rp_out,            // out
    input wire logic [3:0]   rp_out_en          // out enable
);
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    logic [15:0]  s0, s1, s2, rv;
    logic [181:0] p1, p2;
    logic [3:0]   eo, ee;
    logic         e4, e3;
    // shadow copy: selectors are not visible at the ports
    always_ff @(posedge clock) begin
        if (rst) begin
            {s0, s1, s2, p1, p2} <= '0;
        end else begin
            p1 <= remappable_pin;
            p2 <= p1;
            if (wr_en && addr == 4'h0) s0 <= wr_data;
            if (wr_en && addr == 4'h1) s1 <= wr_data & 16'h3F3F;
            if (wr_en && addr == 4'h2) s2 <= wr_data & 16'h3F3F;
        end
    end
    assign rv = (addr == 4'h0) ? s0 : (addr == 4'h1) ? s1 : (addr == 4'h2) ? s2 : 16'h0000;
    assign e4 = s0[15:8] != 8'h00 && s0[15:8] <= 8'hB5 && p2[s0[15:8]];
    assign e3 = s0[7:0] != 8'h00 && s0[7:0] <= 8'hB5 && p2[s0[7:0]];
    assign ee = {s2[13:8] != 6'h00, s2[5:0] != 6'h00, s1[13:8] != 6'h00, s1[5:0] != 6'h00};
    assign eo = ee & {periph_func[s2[13:8]], periph_func[s2[5:0]],
                      periph_func[s1[13:8]], periph_func[s1[5:0]]};
    property p_rd; rd_en |=> rd_data == $past(rv); endproperty
    a_rd: assert property (p_rd) else $error("read data wrong");
    property p_idle; !rd_en |=> rd_data == 16'h0000; endproperty
    a_idle: assert property (p_idle) else $error("read data not zero");
    property p_f4; ##1 pwm_fault_input_4 == $past(e4); endproperty
    a_f4: assert property (p_f4) else $error("fault 4 route wrong");
    property p_f3; 1 |=> pwm_fault_input_3 == $past(e3); endproperty
    a_f3: assert property (p_f3) else $error("fault 3 route wrong");
    property p_o61; 1 |=> {rp_out[1], rp_out_en[1]} == $past({eo[1], ee[1]}); endproperty
    a_o61: assert property (p_o61) else $error("pin 61 wrong");
    property p_o60; 1 |=> {rp_out[0], rp_out_en[0]} == $past({eo[0], ee[0]}); endproperty
    a_o60: assert property (p_o60) else $error("pin 60 wrong");
    property p_o63; 1 |=> {rp_out[3], rp_out_en[3]} == $past({eo[3], ee[3]}); endproperty
    a_o63: assert property (p_o63) else $error("pin 63 wrong");
    property p_o62; 1 |=> {rp_out[2], rp_out_en[2]} == $past({eo[2], ee[2]}); endproperty
    a_o62: assert property (p_o62) else $error("pin 62 wrong");
    c_wr: cover property (wr_en && addr == 4'h1);
    c_f4: cover property (pwm_fault_input_4);
    c_en: cover property (rp_out_en == 4'hB);
endmodule : rps_checker
bind rps_top rps_checker rps_checker_i (.clock(clock), .rst(rst), .addr(addr),
    .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data),
    .remappable_pin(remappable_pin), .periph_func(periph_func),
    .pwm_fault_input_4(pwm_fault_input_4), .pwm_fault_input_3(pwm_fault_input_3),
    .rp_out(rp_out), .rp_out_en(rp_out_en));

// File: tb/rps_top_tb.sv
// self-checking testbench for the remappable pin select block
`timescale 1ns/100ps
module rps_top_tb;
    logic         clock, rst, wr_en, rd_en, f4, f3;
    logic [3:0]   addr, rp_out, rp_out_en;
    logic [15:0]  wr_data, rd_data;
    logic [181:0] remappable_pin;
    logic [63:0]  periph_func;
    int           failures, n_compared;
    rps_top rps_top_i (.clock(clock), .rst(rst), .addr(addr), .wr_data(wr_data),
        .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .remappable_pin(remappable_pin),
        .periph_func(periph_func), .pwm_fault_input_4(f4), .pwm_fault_input_3(f3),
        .rp_out(rp_out), .rp_out_en(rp_out_en));
    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end
    task automatic chk(string what, logic [15:0] seen, logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            failures++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    task automatic wr(logic [3:0] a, logic [15:0] d);
        @(posedge clock);
        addr <= a;
        wr_data <= d;
        wr_en <= 1'b1;
        @(posedge clock);
        wr_en <= 1'b0;
    endtask : wr
    task automatic rd(logic [3:0] a, logic [15:0] e);
        @(posedge clock);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge clock);
        rd_en <= 1'b0;
        #1 chk("rd_data", rd_data, e);
        // read data stand one cycle only, then fall back to zero
        @(posedge clock);
        #1 chk("rd_data idle", rd_data, 16'h0000);
    endtask : rd
    // levels only: three flops is the longest path, so four edges is safe
    task automatic settle();
        repeat (4) @(posedge clock);
        #1;
    endtask : settle
    task automatic t_regs();
        for (int i = 0; i < 3; i++) rd(i[3:0], 16'h0000);
        wr(4'h1, 16'hFFFF);
        rd(4'h1, 16'h3F3F);
        wr(4'h2, 16'hFFFF);
        rd(4'h2, 16'h3F3F);
        wr(4'h0, 16'hFFFF);
        rd(4'h0, 16'hFFFF);
        wr(4'h3, 16'hFFFF);
        rd(4'h3, 16'h0000);
        $display("test regs done");
    endtask : t_regs
    task automatic t_out();
        @(posedge clock);
        periph_func <= 64'h8000_0000_0000_0003;
        wr(4'h1, 16'h3F01);
        wr(4'h2, 16'hC2C0);
        settle();
        chk("rp_out_en", {12'h000, rp_out_en}, 16'h000B);
        chk("rp_out", {12'h000, rp_out}, 16'h0003);
        @(posedge clock);
        periph_func <= 64'h7FFF_FFFF_FFFF_FFFC;
        settle();
        chk("rp_out", {12'h000, rp_out}, 16'h0008);
        wr(4'h2, 16'h0102);
        settle();
        chk("rp_out_en", {12'h000, rp_out_en}, 16'h000F);
        chk("rp_out", {12'h000, rp_out}, 16'h0004);
        $display("test out done");
    endtask : t_out
    task automatic t_flt();
        wr(4'h0, 16'hB5B4);
        remappable_pin <= 182'h1 << 181;
        settle();
        chk("fault", {14'h0000, f4, f3}, 16'h0002);
        @(posedge clock);
        remappable_pin <= 182'h1 << 180;
        settle();
        chk("fault", {14'h0000, f4, f3}, 16'h0001);
        wr(4'h0, 16'hB600);
        remappable_pin <= '1;
        settle();
        chk("fault", {14'h0000, f4, f3}, 16'h0000);
        $display("test fault done");
    endtask : t_flt
    task automatic summarize();
        $display("compared %0d mismatches %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : summarize
    initial begin
        rst = 1'b1;
        {wr_en, rd_en, addr, wr_data, remappable_pin, periph_func} = '0;
        failures = 0;
        n_compared = 0;
        repeat (20) @(posedge clock);
        rst <= 1'b0;
        t_regs();
        t_out();
        t_flt();
        summarize();
    end
endmodule : rps_top_tb
